/* logic/scpps_cfg.svh */
// Constants of the command parser and status reporting block
`ifndef SCPPS_CFG_SVH
`define SCPPS_CFG_SVH
`define SCPPS_CH_LF      8'h0A
`define SCPPS_CH_SPACE   8'h20
`define SCPPS_CH_COLON   8'h3A
`define SCPPS_CH_SEMI    8'h3B
`define SCPPS_CH_STAR    8'h2A
`define SCPPS_CH_QMARK   8'h3F
`define SCPPS_CH_LC_A    8'h61
`define SCPPS_CH_LC_Z    8'h7A
`define SCPPS_CH_CASE    8'h20
`define SCPPS_ERR_SYNTAX 8'h01
`define SCPPS_ERR_HEADER 8'h02
`define SCPPS_ERR_LONG   8'h03
`define SCPPS_SEL_OPER   2'h0
`define SCPPS_SEL_QUES   2'h1
`define SCPPS_SEL_STD    2'h2
`define SCPPS_SEL_SRB    2'h3
`define SCPPS_OP_WTG     5
`define SCPPS_OP_TARM    6
`define SCPPS_OP_CV      8
`define SCPPS_OP_TDONE   9
`define SCPPS_OP_CC      10
`define SCPPS_OP_SDONE   11
`define SCPPS_OP_LDONE   12
`define SCPPS_OP_LRUN    14
`define SCPPS_OPER_RMASK 16'h4D60
`define SCPPS_QU_VMODE   0
`define SCPPS_QU_CMODE   1
`define SCPPS_QU_THERM   3
`define SCPPS_QU_SLAVE   6
`define SCPPS_QU_VPROT   12
`define SCPPS_QU_CPROT   13
`define SCPPS_QU_SINK    14
`define SCPPS_QUES_RMASK 16'h704B
`define SCPPS_STD_RMASK  8'hFF
`define SCPPS_STD_CMDERR 5
`define SCPPS_SRB_QUES   0
`define SCPPS_SRB_ERRQ   3
`define SCPPS_SRB_MAV    4
`define SCPPS_SRB_ESB    5
`define SCPPS_SRB_RQS    6
`define SCPPS_SRB_OPER   7
`define SCPPS_ROOT       5'h00
`define SCPPS_SOUR_NODE  5'h0E
`define SCPPS_RST16      16'h0000
`define SCPPS_RST8       8'h00
`endif

/* logic/scpps_pkg.sv */
// Types shared by the command parser and status reporting block
package scpps_pkg;
  typedef enum logic [2:0] {
    ST_START  = 3'b000,
    ST_KEY    = 3'b001,
    ST_SEP    = 3'b010,
    ST_QRY    = 3'b011,
    ST_DATA   = 3'b100,
    ST_COMMON = 3'b101,
    ST_SKIP   = 3'b110
  } scpps_state_e;
  typedef logic [4:0] scpps_node_t;
endpackage

/* logic/scpps_stgrp.sv */
// One status group: condition edge latch, event and enable registers
`timescale 1ns/10ps
`include "scpps_cfg.svh"
module scpps_stgrp #(
  parameter int           W     = 16,
  parameter logic [W-1:0] RMASK = '1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] cond_in,
  input  wire logic         ena_wr,
  input  wire logic [W-1:0] ena_wdata,
  input  wire logic         evt_rd,
  output logic      [W-1:0] cond_rd,
  output logic      [W-1:0] evt_q,
  output logic              summary
);
  logic [W-1:0] prev_reg;
  logic [W-1:0] evt_reg;
  logic [W-1:0] ena_reg;
  logic [W-1:0] rise;

  if (W < 1 || W > 16) begin : g_bad_width
    $error("scpps_stgrp: W must be 1 to 16");
  end

  assign rise    = cond_in & ~prev_reg;
  assign cond_rd = cond_in & RMASK;
  assign evt_q   = evt_reg;
  assign summary = |(evt_reg & ena_reg);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= cond_in;
    end
  end

  // New edge beats the read clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      evt_reg <= '0;
    end else begin
      evt_reg <= (evt_rd ? '0 : evt_reg) | rise;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ena_reg <= '0;
    end else if (ena_wr) begin
      ena_reg <= ena_wdata;
    end
  end
endmodule

/* logic/scpps_errq.sv */
// Error and event queue holding fault codes in arrival order
`timescale 1ns/10ps
module scpps_errq #(
  parameter int DEPTH = 8
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       push,
  input  wire logic [7:0] push_code,
  input  wire logic       pop,
  output logic            not_empty,
  output logic      [7:0] head_code
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  logic          do_pop;
  logic          do_push;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("scpps_errq: DEPTH must be a power of two, at least 2");
  end

  // When full the newest fault is dropped unless a pop frees a slot in the same cycle
  assign do_pop    = pop & (cnt_reg != '0);
  assign do_push   = push & ((cnt_reg != (AW+1)'(DEPTH)) | do_pop);
  assign not_empty = cnt_reg != '0;
  assign head_code = not_empty ? mem_reg[rd_reg] : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem_reg[wr_reg] <= push_code;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_reg + AW'(do_push);
      rd_reg  <= rd_reg + AW'(do_pop);
      cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

/* logic/scpps_top.sv */
// Remote command tree parser with the status reporting structure
`timescale 1ns/10ps
`include "scpps_cfg.svh"
// Contract
// - Parameter follows final keyword after one space
// - Semicolon starts decoding the next unit
// - Leading colon returns parser to root
// - Line feed ends the program message
// - Terminator or root colon resets tree position
// - Optional source keyword allowed at root
// - Keyword colon moves one level deeper
// - Unit after semicolon stays at previous level
// - Unknown keyword at current level is error
// - Case-blind, exact short or long form
// - Asterisk means common; question mark means query
// - Two 16-bit, one 8-bit status groups
// - Enable masks events into the summary bit
// - Rising condition latches event; read clears
// - Bit 6 ORs enabled bits, drives request
// - Bit 3 queue not empty; bit 4 response
// - Operation condition bit layout, others zero
// - With external source, trigger wait held until input returns high
// - Operation bits 9, 12 are event only
// - Questionable condition bit layout, others zero
// - With external reference, either protection fault sets both bits
module scpps_top
  import scpps_pkg::*;
#(
  parameter int KW_MAX    = 12,
  parameter int ERR_DEPTH = 8
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  output logic             unit_valid,
  output logic [4:0]       unit_node,
  output logic             unit_query,
  output logic             unit_common,
  output logic             unit_end,
  output logic             prm_valid,
  output logic [7:0]       prm_byte,
  input  wire logic        resp_read,
  input  wire logic        err_pop,
  output logic [7:0]       err_code,
  output logic             srq_req,
  input  wire logic        trig_armed,
  input  wire logic        trig_ext_src,
  input  wire logic        trig_in,
  input  wire logic        trans_armed,
  input  wire logic        cv_mode,
  input  wire logic        cc_mode,
  input  wire logic        sample_done,
  input  wire logic        trans_done,
  input  wire logic        list_done,
  input  wire logic        list_running,
  input  wire logic        volt_mode_err,
  input  wire logic        curr_mode_err,
  input  wire logic        thermal_err,
  input  wire logic        slave_fault,
  input  wire logic        vprot_err,
  input  wire logic        cprot_err,
  input  wire logic        sinking,
  input  wire logic        ext_ref_en,
  input  wire logic [7:0]  std_evt_in,
  input  wire logic [1:0]  stat_sel,
  input  wire logic        stat_rd_cond,
  input  wire logic        stat_rd_event,
  input  wire logic        stat_wr_enable,
  input  wire logic [15:0] stat_wdata,
  output logic [15:0]      stat_rdata
);
  localparam int NKW = 24;
  // Keyword text, long length, short length, parent node
  localparam logic [95:0] KW_TXT [1:NKW] = '{
    "STATUS", "OPERATION", "QUESTIONABLE", "PRESET",
    "CONDITION", "ENABLE", "EVENT", "CONDITION", "ENABLE", "EVENT",
    "MEASURE", "VOLTAGE", "CURRENT", "SOURCE", "VOLTAGE", "CURRENT",
    "LEVEL", "LEVEL", "TRIGGER", "INITIATE", "OUTPUT", "SYSTEM",
    "ERROR", "FUNCTION"};
  localparam logic [3:0] KW_LL [1:NKW] = '{
    4'h6, 4'h9, 4'hC, 4'h6, 4'h9, 4'h6, 4'h5, 4'h9, 4'h6, 4'h5,
    4'h7, 4'h7, 4'h7, 4'h6, 4'h7, 4'h7, 4'h5, 4'h5, 4'h7, 4'h8,
    4'h6, 4'h6, 4'h5, 4'h8};
  localparam logic [3:0] KW_SL [1:NKW] = '{
    4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4,
    4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h3, 4'h3, 4'h4, 4'h4,
    4'h4, 4'h4, 4'h3, 4'h4};
  localparam logic [4:0] KW_PAR [1:NKW] = '{
    5'h00, 5'h01, 5'h01, 5'h01, 5'h02, 5'h02, 5'h02, 5'h03, 5'h03,
    5'h03, 5'h00, 5'h0B, 5'h0B, 5'h00, 5'h0E, 5'h0E, 5'h0F, 5'h10,
    5'h00, 5'h00, 5'h00, 5'h00, 5'h16, 5'h0E};

  scpps_state_e            state_reg;
  scpps_state_e            st_next;
  scpps_node_t             level_reg;
  scpps_node_t             lvl_next;
  scpps_node_t             last_reg;
  scpps_node_t             hit;
  logic [KW_MAX*8-1:0]     kw_buf_reg;
  logic [3:0]              kw_len_reg;
  logic [7:0]              ch;
  logic                    rx_fire;
  logic                    is_kwch;
  logic                    fault;
  logic [7:0]              fcode;
  logic                    emit;
  logic                    app;
  logic                    clr;
  logic                    last_ld;
  logic                    qry_set;
  logic                    com_set;
  logic                    prm;
  logic                    qry_reg;
  logic                    com_reg;
  logic                    fault_reg;
  logic                    resp_reg;
  logic                    wtg_hold_reg;
  logic                    trigger_wait_flag;
  logic [15:0]             oper_cond;
  logic [15:0]             ques_cond;
  logic [7:0]              std_cond;
  logic [15:0]             oper_rd;
  logic [15:0]             ques_rd;
  logic [7:0]              std_rd;
  logic [15:0]             oper_evt;
  logic [15:0]             ques_evt;
  logic [7:0]              std_evt;
  logic                    oper_sum;
  logic                    ques_sum;
  logic                    std_sum;
  logic                    errq_ne;
  logic [7:0]              sre_reg;
  logic [7:0]              srb_base;
  logic [7:0]              srb;
  logic                    rqs;
  logic                    prot_any;

  if (KW_MAX < 12 || KW_MAX > 15) begin : g_bad_kw
    $error("scpps_top: KW_MAX must be 12 to 15");
  end

  function automatic logic [7:0] to_upper(input logic [7:0] c);
    if (c >= `SCPPS_CH_LC_A && c <= `SCPPS_CH_LC_Z) begin
      return c & ~`SCPPS_CH_CASE;
    end
    return c;
  endfunction

  // Match exact short or exact long form below the given parent
  function automatic scpps_node_t kw_find(input scpps_node_t par);
    logic        ok_s;
    logic        ok_l;
    scpps_node_t found;
    found = `SCPPS_ROOT;
    for (int k = 1; k <= NKW; k++) begin
      ok_s = kw_len_reg == KW_SL[k];
      ok_l = kw_len_reg == KW_LL[k];
      for (int i = 0; i < KW_MAX; i++) begin
        if (i < int'(KW_LL[k])) begin
          if (kw_buf_reg[8*i +: 8] != KW_TXT[k][8*(int'(KW_LL[k])-1-i) +: 8]) begin
            ok_l = 1'b0;
            if (i < int'(KW_SL[k])) begin
              ok_s = 1'b0;
            end
          end
        end
      end
      if (KW_PAR[k] == par && (ok_s || ok_l)) begin
        found = 5'(k);
      end
    end
    return found;
  endfunction

  assign rx_ready = ~unit_valid;
  assign rx_fire  = rx_valid & rx_ready;
  assign ch       = to_upper(rx_data);
  assign is_kwch  = (ch >= 8'h41 && ch <= 8'h5A) || (ch >= 8'h30 && ch <= 8'h39)
                    || ch == 8'h5F;

  // Source keyword is implied when nothing matches at the root
  always_comb begin
    hit = kw_find(level_reg);
    if (hit == `SCPPS_ROOT && level_reg == `SCPPS_ROOT) begin
      hit = kw_find(`SCPPS_SOUR_NODE);
    end
  end

  always_comb begin
    st_next  = state_reg;
    lvl_next = level_reg;
    fault    = 1'b0;
    fcode    = `SCPPS_ERR_SYNTAX;
    emit     = 1'b0;
    app      = 1'b0;
    clr      = 1'b0;
    last_ld  = 1'b0;
    qry_set  = 1'b0;
    com_set  = 1'b0;
    prm      = 1'b0;
    if (rx_fire) begin
      case (state_reg)
        ST_START: begin
          if (ch == `SCPPS_CH_LF) begin
            lvl_next = `SCPPS_ROOT;
          end else if (ch == `SCPPS_CH_SPACE) begin
            st_next = ST_START;
          end else if (ch == `SCPPS_CH_COLON) begin
            lvl_next = `SCPPS_ROOT;
            st_next  = ST_SEP;
          end else if (ch == `SCPPS_CH_STAR) begin
            com_set = 1'b1;
            st_next = ST_COMMON;
          end else if (is_kwch) begin
            app     = 1'b1;
            st_next = ST_KEY;
          end else begin
            fault = 1'b1;
          end
        end
        ST_SEP: begin
          if (is_kwch) begin
            app     = 1'b1;
            st_next = ST_KEY;
          end else begin
            fault = 1'b1;
          end
        end
        ST_KEY: begin
          if (is_kwch) begin
            if (kw_len_reg == 4'(KW_MAX)) begin
              fault = 1'b1;
              fcode = `SCPPS_ERR_LONG;
            end else begin
              app = 1'b1;
            end
          end else if (ch == `SCPPS_CH_COLON || ch == `SCPPS_CH_QMARK
                       || ch == `SCPPS_CH_SPACE || ch == `SCPPS_CH_SEMI
                       || ch == `SCPPS_CH_LF) begin
            if (hit == `SCPPS_ROOT) begin
              fault = 1'b1;
              fcode = `SCPPS_ERR_HEADER;
            end else begin
              last_ld = 1'b1;
              clr     = 1'b1;
              if (ch == `SCPPS_CH_COLON) begin
                lvl_next = hit;
                st_next  = ST_SEP;
              end else if (ch == `SCPPS_CH_QMARK) begin
                qry_set = 1'b1;
                st_next = ST_QRY;
              end else if (ch == `SCPPS_CH_SPACE) begin
                st_next = ST_DATA;
              end else if (ch == `SCPPS_CH_SEMI) begin
                emit    = 1'b1;
                st_next = ST_START;
              end else begin
                emit     = 1'b1;
                lvl_next = `SCPPS_ROOT;
                st_next  = ST_START;
              end
            end
          end else begin
            fault = 1'b1;
          end
        end
        ST_QRY, ST_COMMON: begin
          if (state_reg == ST_COMMON && is_kwch) begin
            st_next = ST_COMMON;
          end else if (state_reg == ST_COMMON && ch == `SCPPS_CH_QMARK) begin
            qry_set = 1'b1;
            st_next = ST_QRY;
          end else if (ch == `SCPPS_CH_SPACE) begin
            st_next = ST_DATA;
          end else if (ch == `SCPPS_CH_SEMI) begin
            emit    = 1'b1;
            st_next = ST_START;
          end else if (ch == `SCPPS_CH_LF) begin
            emit     = 1'b1;
            lvl_next = `SCPPS_ROOT;
            st_next  = ST_START;
          end else begin
            fault = 1'b1;
          end
        end
        ST_DATA: begin
          // Quoted strings holding separators are not supported
          if (ch == `SCPPS_CH_SEMI) begin
            emit    = 1'b1;
            st_next = ST_START;
          end else if (ch == `SCPPS_CH_LF) begin
            emit     = 1'b1;
            lvl_next = `SCPPS_ROOT;
            st_next  = ST_START;
          end else begin
            prm = 1'b1;
          end
        end
        ST_SKIP: begin
          if (ch == `SCPPS_CH_LF) begin
            lvl_next = `SCPPS_ROOT;
            st_next  = ST_START;
          end
        end
        default: begin
          st_next = ST_START;
        end
      endcase
      if (fault) begin
        clr = 1'b1;
        if (ch == `SCPPS_CH_LF) begin
          lvl_next = `SCPPS_ROOT;
          st_next  = ST_START;
        end else begin
          st_next = ST_SKIP;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_START;
      level_reg <= `SCPPS_ROOT;
    end else begin
      state_reg <= st_next;
      level_reg <= lvl_next;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      kw_buf_reg <= '0;
      kw_len_reg <= 4'h0;
    end else if (clr) begin
      kw_len_reg <= 4'h0;
    end else if (app) begin
      kw_buf_reg[8*kw_len_reg +: 8] <= ch;
      kw_len_reg                    <= kw_len_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      last_reg <= `SCPPS_ROOT;
      qry_reg  <= 1'b0;
      com_reg  <= 1'b0;
    end else begin
      if (last_ld) begin
        last_reg <= hit;
      end else if (com_set) begin
        last_reg <= `SCPPS_ROOT;
      end
      qry_reg <= (qry_reg | qry_set) & ~emit & ~fault;
      com_reg <= (com_reg | com_set) & ~emit & ~fault;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      unit_valid  <= 1'b0;
      unit_node   <= `SCPPS_ROOT;
      unit_query  <= 1'b0;
      unit_common <= 1'b0;
      unit_end    <= 1'b0;
      prm_valid   <= 1'b0;
      prm_byte    <= 8'h00;
    end else begin
      unit_valid <= emit;
      prm_valid  <= prm;
      if (emit) begin
        unit_node   <= last_ld ? hit : last_reg;
        unit_query  <= qry_reg;
        unit_common <= com_reg;
        unit_end    <= ch == `SCPPS_CH_LF;
      end
      if (prm) begin
        prm_byte <= rx_data;
      end
    end
  end

  // Query answer stays pending until the reader takes it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      resp_reg  <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      resp_reg  <= (resp_read ? 1'b0 : resp_reg) | (emit & qry_reg);
      fault_reg <= fault;
    end
  end

  scpps_errq #(
    .DEPTH(ERR_DEPTH)
  ) u_errq (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .push      (fault),
    .push_code (fcode),
    .pop       (err_pop),
    .not_empty (errq_ne),
    .head_code (err_code)
  );

  // External trigger low keeps the wait flag until it rises again
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wtg_hold_reg <= 1'b0;
    end else begin
      wtg_hold_reg <= trig_ext_src & ~trig_in & trigger_wait_flag;
    end
  end
  assign trigger_wait_flag      = trig_armed | wtg_hold_reg;
  assign prot_any = vprot_err | cprot_err;

  always_comb begin
    oper_cond                  = `SCPPS_RST16;
    oper_cond[`SCPPS_OP_WTG]   = trigger_wait_flag;
    oper_cond[`SCPPS_OP_TARM]  = trans_armed;
    oper_cond[`SCPPS_OP_CV]    = cv_mode;
    oper_cond[`SCPPS_OP_TDONE] = trans_done;
    oper_cond[`SCPPS_OP_CC]    = cc_mode;
    oper_cond[`SCPPS_OP_SDONE] = sample_done;
    oper_cond[`SCPPS_OP_LDONE] = list_done;
    oper_cond[`SCPPS_OP_LRUN]  = list_running;
    ques_cond                  = `SCPPS_RST16;
    ques_cond[`SCPPS_QU_VMODE] = volt_mode_err;
    ques_cond[`SCPPS_QU_CMODE] = curr_mode_err;
    ques_cond[`SCPPS_QU_THERM] = thermal_err;
    ques_cond[`SCPPS_QU_SLAVE] = slave_fault;
    ques_cond[`SCPPS_QU_VPROT] = vprot_err | (ext_ref_en & prot_any);
    ques_cond[`SCPPS_QU_CPROT] = cprot_err | (ext_ref_en & prot_any);
    ques_cond[`SCPPS_QU_SINK]  = sinking;
    std_cond                   = std_evt_in;
    std_cond[`SCPPS_STD_CMDERR] = std_evt_in[`SCPPS_STD_CMDERR] | fault_reg;
  end

  // Condition read masks hide the event-only operation bits
  scpps_stgrp #(
    .W     (16),
    .RMASK (`SCPPS_OPER_RMASK)
  ) u_oper (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .cond_in   (oper_cond),
    .ena_wr    (stat_wr_enable && stat_sel == `SCPPS_SEL_OPER),
    .ena_wdata (stat_wdata),
    .evt_rd    (stat_rd_event && stat_sel == `SCPPS_SEL_OPER),
    .cond_rd   (oper_rd),
    .evt_q     (oper_evt),
    .summary   (oper_sum)
  );

  scpps_stgrp #(
    .W     (16),
    .RMASK (`SCPPS_QUES_RMASK)
  ) u_ques (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .cond_in   (ques_cond),
    .ena_wr    (stat_wr_enable && stat_sel == `SCPPS_SEL_QUES),
    .ena_wdata (stat_wdata),
    .evt_rd    (stat_rd_event && stat_sel == `SCPPS_SEL_QUES),
    .cond_rd   (ques_rd),
    .evt_q     (ques_evt),
    .summary   (ques_sum)
  );

  scpps_stgrp #(
    .W     (8),
    .RMASK (`SCPPS_STD_RMASK)
  ) u_std (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .cond_in   (std_cond),
    .ena_wr    (stat_wr_enable && stat_sel == `SCPPS_SEL_STD),
    .ena_wdata (stat_wdata[7:0]),
    .evt_rd    (stat_rd_event && stat_sel == `SCPPS_SEL_STD),
    .cond_rd   (std_rd),
    .evt_q     (std_evt),
    .summary   (std_sum)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sre_reg <= `SCPPS_RST8;
    end else if (stat_wr_enable && stat_sel == `SCPPS_SEL_SRB) begin
      sre_reg <= stat_wdata[7:0];
    end
  end

  always_comb begin
    srb_base                  = `SCPPS_RST8;
    srb_base[`SCPPS_SRB_QUES] = ques_sum;
    srb_base[`SCPPS_SRB_ERRQ] = errq_ne;
    srb_base[`SCPPS_SRB_MAV]  = resp_reg;
    srb_base[`SCPPS_SRB_ESB]  = std_sum;
    srb_base[`SCPPS_SRB_OPER] = oper_sum;
    rqs                       = |(srb_base & sre_reg);
    srb                       = srb_base;
    srb[`SCPPS_SRB_RQS]       = rqs;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      srq_req    <= 1'b0;
      stat_rdata <= `SCPPS_RST16;
    end else begin
      srq_req <= rqs;
      if (stat_rd_cond || stat_rd_event) begin
        case (stat_sel)
          `SCPPS_SEL_OPER: stat_rdata <= stat_rd_event ? oper_evt : oper_rd;
          `SCPPS_SEL_QUES: stat_rdata <= stat_rd_event ? ques_evt : ques_rd;
          `SCPPS_SEL_STD:  stat_rdata <= {8'h00, stat_rd_event ? std_evt : std_rd};
          default:         stat_rdata <= {8'h00, srb};
        endcase
      end
    end
  end
endmodule

/* test/scpps_checker.sv */
// Port checker of the parser and status block
`timescale 1ns/10ps
module scpps_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  rx_data,
  input wire logic        unit_valid,
  input wire logic [4:0]  unit_node,
  input wire logic        unit_common,
  input wire logic        unit_end,
  input wire logic        prm_valid,
  input wire logic [7:0]  prm_byte,
  input wire logic        srq_req,
  input wire logic        cv_mode,
  input wire logic [1:0]  stat_sel,
  input wire logic        stat_rd_cond,
  input wire logic        stat_rd_event,
  input wire logic [15:0] stat_rdata
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  lf_end_a: assert property (unit_valid && unit_end |-> $past(rx_data) == 8'h0A)
    else $error("unit closed without line feed");
  semi_end_a: assert property (unit_valid && !unit_end |-> $past(rx_data) == 8'h3B)
    else $error("unit closed without semicolon");
  prm_copy_a: assert property (prm_valid |-> prm_byte == $past(rx_data))
    else $error("parameter byte differs from input");
  common_node_a: assert property (unit_valid && unit_common |-> unit_node == 5'h00)
    else $error("common unit carries a keyword id");
  oper_mask_a: assert property (stat_rd_cond && stat_sel == 2'h0 |=>
    (stat_rdata & ~16'h4D60) == 16'h0000) else $error("unused operation bit set");
  ques_mask_a: assert property (stat_rd_cond && stat_sel == 2'h1 |=>
    (stat_rdata & ~16'h704B) == 16'h0000) else $error("unused questionable bit set");
  cv_bit_a: assert property (stat_rd_cond && stat_sel == 2'h0 |=>
    stat_rdata[8] == $past(cv_mode)) else $error("voltage mode bit wrong");
  byte_grp_a: assert property ((stat_rd_cond || stat_rd_event) && stat_sel[1] |=>
    stat_rdata[15:8] == 8'h00) else $error("byte group upper half set");
  cover property (unit_valid && unit_common);
  cover property (prm_valid);
  cover property ($rose(srq_req));
endmodule
bind scpps_top scpps_checker u_scpps_checker (.*);

/* test/scpps_host.sv */
// Host model offering message characters to the parser
`timescale 1ns/10ps
module scpps_host (
  input  wire logic       ref_clk,
  output logic            rx_valid,
  output logic      [7:0] rx_data
);
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'hA5;
  end
  task automatic send(input string s, input int gap);
    s = {s, "\n"};
    foreach (s[i]) begin
      repeat (gap) @(negedge ref_clk);
      @(negedge ref_clk);
      rx_valid = 1'b1;
      rx_data  = s[i];
      @(negedge ref_clk);
      rx_valid = 1'b0;
      // Released line shows the inverse, never a stale char
      rx_data  = ~s[i];
    end
    repeat (2) @(negedge ref_clk);
  endtask
endmodule

/* test/scpps_top_tb_top.sv */
// Self-checking bench of the parser and status block
`timescale 1ns/10ps
module scpps_top_tb_top;
  logic ref_clk, rst, rx_valid, rx_ready, unit_valid, unit_query, unit_common, unit_end;
  logic prm_valid, resp_read, err_pop, srq_req, trig_armed, trig_ext_src, trig_in, ext_ref_en;
  logic stat_rd_cond, stat_rd_event, stat_wr_enable, trans_armed, cv_mode, cc_mode;
  logic sample_done, trans_done, list_done, list_running, volt_mode_err, curr_mode_err;
  logic thermal_err, slave_fault, vprot_err, cprot_err, sinking;
  logic [4:0]  unit_node;
  logic [7:0]  rx_data, prm_byte, err_code, std_evt_in, uq[$];
  logic [1:0]  stat_sel;
  logic [15:0] stat_wdata, stat_rdata;
  logic [13:0] cn;
  int          error_cnt, compares;
  int          pos[14] = '{6, 8, 9, 10, 11, 12, 14, 0, 1, 3, 6, 12, 13, 14};
  assign {sinking, cprot_err, vprot_err, slave_fault, thermal_err, curr_mode_err,
          volt_mode_err, list_running, list_done, sample_done, cc_mode, trans_done,
          cv_mode, trans_armed} = cn;
  scpps_top u_scpps_top (.*);
  scpps_host u_scpps_host (.*);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) if (unit_valid === 1'b1) begin
    uq.push_back({unit_node, unit_common, unit_query, unit_end});
    chk("ready", rx_ready, 16'h0000);
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic msg(input string s, input logic [7:0] e0, input logic [7:0] e1);
    uq.delete();
    u_scpps_host.send(s, 0);
    chk("unit", uq.pop_front(), e0);
    if (e1 !== 8'h00) chk("unit", uq.pop_front(), e1);
  endtask
  task automatic rd(input logic [1:0] sel, input logic ev, input logic [15:0] e);
    @(negedge ref_clk);
    {stat_sel, stat_rd_cond, stat_rd_event} = {sel, ~ev, ev};
    @(negedge ref_clk);
    {stat_rd_cond, stat_rd_event} = 2'b00;
    chk("status", stat_rdata, e);
  endtask
  task automatic wen(input logic [1:0] sel, input logic [15:0] d);
    @(negedge ref_clk);
    {stat_sel, stat_wdata, stat_wr_enable} = {sel, d, 1'b1};
    @(negedge ref_clk);
    stat_wr_enable = 1'b0;
  endtask
  task automatic pop(input logic r);
    @(negedge ref_clk);
    {resp_read, err_pop} = {r, ~r};
    @(negedge ref_clk);
    {resp_read, err_pop} = 2'b00;
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200us;
    error_cnt++;
    complete_run();
  end
  initial begin
    {cn, trig_armed, trig_ext_src, trig_in, ext_ref_en, resp_read, err_pop, std_evt_in} = '0;
    {stat_sel, stat_rd_cond, stat_rd_event, stat_wr_enable, stat_wdata} = '0;
    rst = 1'b1;
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    for (int g = 0; g < 3; g++) rd(g[1:0], 1'b1, 16'h0000);
    msg("VOLT 5", 8'h79, 8'h00);
    chk("param", prm_byte, 16'h0035);
    msg("meas:volt?;curr?", 8'h62, 8'h6B);
    msg("VOLT 5;:CURR 1", 8'h78, 8'h81);
    msg("STAT:OPER:COND?;ENAB 16", 8'h2A, 8'h31);
    msg("*CLS", 8'h05, 8'h00);
    msg(":Source:Voltage:LEVel 3", 8'h89, 8'h00);
    rd(2'h3, 1'b0, 16'h0010);
    u_scpps_host.send("VOLTA 5", 0);
    u_scpps_host.send("MEAS:VOLT?;OUTP 1", 1);
    u_scpps_host.send("QUESTIONABLEX 1", 0);
    rd(2'h3, 1'b0, 16'h0018);
    rd(2'h2, 1'b1, 16'h0020);
    for (int c = 0; c < 3; c++) begin
      chk("error", err_code, (c < 2) ? 16'h0002 : 16'h0003);
      pop(1'b0);
    end
    pop(1'b1);
    rd(2'h3, 1'b0, 16'h0000);
    for (int i = 0; i < 14; i++) begin
      cn = 14'h0001 << i;
      rd(i > 6, 1'b0, (i == 2 || i == 5) ? 16'h0000 : 16'h0001 << pos[i]);
      rd(i > 6, 1'b1, 16'h0001 << pos[i]);
      rd(i > 6, 1'b1, 16'h0000);
      cn = '0;
    end
    {ext_ref_en, cn} = {1'b1, 14'h0800};
    rd(2'h1, 1'b0, 16'h3000);
    {ext_ref_en, cn, std_evt_in} = {15'h0000, 8'h81};
    rd(2'h2, 1'b1, 16'h0081);
    {trig_ext_src, trig_in, trig_armed} = 3'b111;
    rd(2'h0, 1'b0, 16'h0020);
    trig_in = 1'b0;
    rd(2'h0, 1'b0, 16'h0020);
    trig_armed = 1'b0;
    rd(2'h0, 1'b0, 16'h0020);
    trig_in = 1'b1;
    rd(2'h0, 1'b0, 16'h0000);
    rd(2'h0, 1'b1, 16'h0020);
    wen(2'h0, 16'h0100);
    wen(2'h3, 16'h0080);
    cn = 14'h0002;
    repeat (4) @(negedge ref_clk);
    chk("srq", srq_req, 16'h0001);
    rd(2'h0, 1'b1, 16'h0100);
    repeat (3) @(negedge ref_clk);
    chk("srq", srq_req, 16'h0000);
    complete_run();
  end
endmodule
